/* hw/slt_pkg.sv */
// Shared constants and types of the synchronous line transmit sequencer
package slt_pkg;
   // Register word offsets of the local register port
   localparam logic [3:0] ADDR_MAINT  = 4'h0;
   localparam logic [3:0] ADDR_OUTCTL = 4'h4;
   localparam logic [3:0] ADDR_TXDATA = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hC;
   localparam logic [3:0] ADDR_SYNC   = 4'h1;
   // Field positions
   localparam int MAINT_MODE_BIT  = 0;
   localparam int MAINT_TDIS_BIT  = 1;
   localparam int OUT_SOM_BIT     = 0;
   localparam int OUT_EOM_BIT     = 1;
   localparam int ST_DONE_BIT     = 0;
   localparam int ST_ACTIVE_BIT   = 1;
   localparam int ST_LATE_BIT     = 2;
   localparam int ST_SB_LSB       = 8;
   // Reset values and check polynomial
   localparam logic [7:0]  SYNC_RESET  = 8'h96;
   localparam logic [15:0] CRC_INIT    = 16'hFFFF;
   localparam logic [15:0] CRC_POLY    = 16'h1021;
   // Table selectors
   localparam logic [1:0] KIND_FUNC = 2'h0;
   localparam logic [1:0] KIND_PATH = 2'h1;
   localparam logic [1:0] KIND_DATA = 2'h2;
   // Bit counter and ones counter figures
   localparam logic [2:0] BITS_LAST   = 3'h7;
   localparam logic [2:0] ONES_FIVE   = 3'h5;
   localparam logic [2:0] ONES_SIX    = 3'h6;
   localparam logic [2:0] ONES_SAT    = 3'h7;
   localparam logic       LINE_MARK   = 1'b1;

   // Registered state buffer, six bits
   typedef struct packed {
      logic flag;
      logic check;
      logic active;
      logic eom;
      logic som;
      logic abort;
   } slt_state_type;

   // Function decode outputs
   typedef struct packed {
      logic flag;
      logic check;
      logic active;
      logic done_preset;
   } slt_func_type;

   // Data path control outputs
   typedef struct packed {
      logic force_space;
      logic select_check_bits;
      logic select_shift_register;
      logic bit_counter_enable;
   } slt_path_type;

   // Data decode outputs
   typedef struct packed {
      logic line_bit;
      logic check_clock_enable;
      logic silo_transfer;
      logic shift_clock_qualifier;
   } slt_data_type;
endpackage

/* hw/slt_table.sv */
// Fixed 256 x 4 decision table, contents chosen by KIND
`timescale 1ns/1ps
module slt_table #(
   parameter logic [1:0] KIND = slt_pkg::KIND_FUNC
) (
   input  wire logic [7:0] addr,
   input  wire logic       enable,
   output logic      [3:0] word
);
   // Function decode: {flag, check, active, done_preset}
   function automatic logic [3:0] func_word(input logic [7:0] a);
      logic [3:0] r;
      r = 4'h0;
      if (a[5] && a[0]) begin
         if (!a[4]) begin
            r = a[2] ? 4'hB : 4'h0;
         end else if (a[1]) begin
            if (a[3]) begin
               r = 4'h0;
            end else if (!a[2] && !a[6]) begin
               r = 4'h6;
            end else begin
               r = 4'hA;
            end
         end else begin
            r = 4'h3;
         end
      end
      return r;
   endfunction

   // Data path control: {force_space, sel_check, sel_shift, count_enable}
   function automatic logic [3:0] path_word(input logic [7:0] a);
      logic [3:0] r;
      r = 4'h1;
      if (a[3] || a[6]) begin
         r = 4'h1;
      end else if (a[5]) begin
         r = a[7] ? 4'h3 : (a[2] ? 4'h9 : 4'h1);
      end else if (a[4]) begin
         r = (!a[7] && a[1]) ? 4'h8 : 4'h5;
      end else begin
         r = (!a[7] && a[1]) ? 4'h8 : 4'h3;
      end
      return r;
   endfunction

   // Data decode: {line_bit, check_enable, transfer, shift_qualifier}
   function automatic logic [3:0] data_word(input logic [7:0] a);
      logic [3:0] r;
      r = 4'h0;
      r[3] = a[5] ? 1'b0 : (a[3] ? a[2] : (a[1] ? a[0] : 1'b1));
      r[2] = a[1] && !a[5] && !a[4];
      r[1] = a[6];
      r[0] = a[1] && !a[5] && !a[3] && !a[6];
      return r;
   endfunction

   // Same address always gives the same word; disabled reads as zero
   always_comb begin
      word = 4'h0;
      if (enable) begin
         case (KIND)
            slt_pkg::KIND_FUNC: word = func_word(addr);
            slt_pkg::KIND_PATH: word = path_word(addr);
            default:            word = data_word(addr);
         endcase
      end
   end
endmodule

/* hw/slt_tx_sequencer.sv */
// Transmitter control sequencer of a synchronous line unit
//
// Contract
// - Each table: fixed 256 by 4 lookup
// - Function table sets done, picks next event
// - Send permitted is clear-to-send AND set-ready
// - Function table inputs: mode, strap, state, load
// - Send flag is check OR start state
// - Three outputs feed buffer, fourth presets done
// - State buffer holds six bits
// - Active stays clear until opening character starts
// - Inactive: buffer loads every bit time
// - Active: buffer loads only at last bit
// - Buffer outputs change only on load
// - Path table formats stuffing control characters
// - Path table drives selects and counter enable
// - Stuffed zero is not counted
// - Data table selects serial output source
// - Data table times silo to shift transfer
// - Shift clock withheld for check, stuff, and control outside byte-count mode
// - Maintenance bit disables two tables, not path
// - Late service forces line to mark
// - Check bits accumulate only when enabled
`timescale 1ns/1ps
module slt_tx_sequencer #(
   parameter int DATA_W = 16
) (
   input  wire logic              clock,
   input  wire logic              rstn,
   input  wire logic [3:0]        reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   input  wire logic              modem_cts,
   input  wire logic              modem_dsr,
   input  wire logic              modem_tx_clock,
   input  wire logic              no_check_bits_strap,
   output logic                   tx_line,
   output logic                   transmit_done
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic                 mode_ff;
   logic                 table_disable_ff;
   logic                 som_ff;
   logic                 eom_ff;
   logic [7:0]           tx_data_ff;
   logic [7:0]           sync_ff;
   logic                 done_ff;
   logic                 late_ff;
   logic [DATA_W-1:0]    rdata_ff;
   logic [1:0]           cts_sync_ff;
   logic [1:0]           dsr_sync_ff;
   logic [1:0]           clk_sync_ff;
   logic [1:0]           strap_sync_ff;
   logic                 clk_prev_ff;
   logic                 bit_tick;
   slt_pkg::slt_state_type sb_ff;
   slt_pkg::slt_state_type nxt_sb;
   slt_pkg::slt_func_type  func_out;
   slt_pkg::slt_path_type  path_out;
   slt_pkg::slt_data_type  data_out;
   logic [3:0]           func_word;
   logic [3:0]           path_word;
   logic [3:0]           data_word;
   logic [7:0]           func_addr;
   logic [7:0]           path_addr;
   logic [7:0]           data_addr;
   logic                 send_permitted;
   logic                 send_flag_combined;
   logic                 last_bit_of_character;
   logic                 load;
   logic                 state_buffer_load;
   logic                 table_enable;
   logic [2:0]           bit_count_ff;
   logic [2:0]           ones_ff;
   logic                 ones_five;
   logic                 ones_six;
   logic [7:0]           shift_ff;
   logic [15:0]          check_ff;
   logic                 line_ff;
   logic                 check_feedback;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: only the second stage is read
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cts_sync_ff   <= 2'h0;
         dsr_sync_ff   <= 2'h0;
         clk_sync_ff   <= 2'h0;
         strap_sync_ff <= 2'h0;
      end else begin
         cts_sync_ff   <= {cts_sync_ff[0], modem_cts};
         dsr_sync_ff   <= {dsr_sync_ff[0], modem_dsr};
         clk_sync_ff   <= {clk_sync_ff[0], modem_tx_clock};
         strap_sync_ff <= {strap_sync_ff[0], no_check_bits_strap};
      end
   end

   // Falling edge of the modem clock is the rising edge of its inverse
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         clk_prev_ff <= 1'b0;
      end else begin
         clk_prev_ff <= clk_sync_ff[1];
      end
   end

   assign bit_tick = clk_prev_ff && !clk_sync_ff[1];

   ////////////////////////////////////////////////////////////////////////////
   // Decision tables
   assign send_permitted     = cts_sync_ff[1] && dsr_sync_ff[1];
   assign send_flag_combined = sb_ff.check || sb_ff.som;
   // Test disable hits two tables, never the path table
   assign table_enable       = !table_disable_ff;

   // First listed input is the address MSB
   assign func_addr = {mode_ff, strap_sync_ff[1], send_permitted, sb_ff.active,
                       sb_ff.flag, send_flag_combined, eom_ff, load};
   assign path_addr = {mode_ff, sb_ff.abort, sb_ff.flag, sb_ff.check, 1'b0,
                       ones_six, ones_five, load};
   assign data_addr = {sb_ff.som, load, path_out.force_space, sb_ff.flag,
                       path_out.select_check_bits, check_ff[15],
                       path_out.select_shift_register, shift_ff[0]};

   // Function decode picks the next event per character
   slt_table #(
      .KIND (slt_pkg::KIND_FUNC)
   ) u_function_decode_table (
      .addr   (func_addr),
      .enable (table_enable),
      .word   (func_word)
   );

   // Data path control, formats control characters
   slt_table #(
      .KIND (slt_pkg::KIND_PATH)
   ) u_data_path_control_table (
      .addr   (path_addr),
      .enable (1'b1),
      .word   (path_word)
   );

   // Data decode, chooses the line bit and times transfers
   slt_table #(
      .KIND (slt_pkg::KIND_DATA)
   ) u_data_decode_table (
      .addr   (data_addr),
      .enable (table_enable),
      .word   (data_word)
   );

   assign func_out = slt_pkg::slt_func_type'(func_word);
   assign path_out = slt_pkg::slt_path_type'(path_word);
   assign data_out = slt_pkg::slt_data_type'(data_word);

   ////////////////////////////////////////////////////////////////////////////
   // State buffer load timing
   assign ones_five             = ones_ff >= slt_pkg::ONES_FIVE;
   assign ones_six              = ones_ff >= slt_pkg::ONES_SIX;
   // Last bit counts only when the counter is enabled, so stuffing delays it
   assign last_bit_of_character = (bit_count_ff == slt_pkg::BITS_LAST)
                                  && path_out.bit_counter_enable;
   assign load                  = !sb_ff.active || last_bit_of_character;
   assign state_buffer_load     = bit_tick && load;

   // Next buffer: three table bits, two silo bits, abort
   always_comb begin
      nxt_sb        = sb_ff;
      nxt_sb.flag   = func_out.flag;
      nxt_sb.check  = func_out.check;
      nxt_sb.active = func_out.active;
      nxt_sb.eom    = eom_ff;
      nxt_sb.som    = som_ff;
      nxt_sb.abort  = late_ff;
   end

   // Outputs move only here, so software may change inputs mid-character
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sb_ff <= '0;
      end else if (state_buffer_load) begin
         sb_ff <= nxt_sb;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Character bit counter, held at zero while inactive
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bit_count_ff <= 3'h0;
      end else if (bit_tick) begin
         if (!sb_ff.active) begin
            bit_count_ff <= 3'h0;
         end else if (path_out.bit_counter_enable) begin
            bit_count_ff <= bit_count_ff + 3'h1;
         end
      end
   end

   // Consecutive ones sent on the line, saturating
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ones_ff <= 3'h0;
      end else if (bit_tick) begin
         if (!data_out.line_bit) begin
            ones_ff <= 3'h0;
         end else if (ones_ff != slt_pkg::ONES_SAT) begin
            ones_ff <= ones_ff + 3'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shift register: silo load or shift
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         shift_ff <= 8'h00;
      end else if (state_buffer_load && data_out.silo_transfer) begin
         // Byte-count mode sends the sync pattern for flag characters
         shift_ff <= (func_out.flag && mode_ff) ? sync_ff : tx_data_ff;
      end else if (bit_tick && data_out.shift_clock_qualifier) begin
         shift_ff <= {1'b0, shift_ff[7:1]};
      end
   end

   // Check bits: preset to all ones during flags, accumulate on data, shift out after
   assign check_feedback = check_ff[15] ^ data_out.line_bit;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         check_ff <= slt_pkg::CRC_INIT;
      end else if (bit_tick) begin
         if (sb_ff.flag) begin
            check_ff <= slt_pkg::CRC_INIT;
         end else if (data_out.check_clock_enable) begin
            check_ff <= {check_ff[14:0], 1'b0}
                        ^ (check_feedback ? slt_pkg::CRC_POLY : 16'h0000);
         end else if (path_out.select_check_bits && path_out.bit_counter_enable) begin
            check_ff <= {check_ff[14:0], 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Idle or late service holds the line at mark
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         line_ff <= slt_pkg::LINE_MARK;
      end else if (bit_tick) begin
         if (!sb_ff.active || sb_ff.abort || late_ff) begin
            line_ff <= slt_pkg::LINE_MARK;
         end else begin
            line_ff <= data_out.line_bit;
         end
      end
   end

   assign tx_line = line_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Transmit done: preset by the table, cleared by a data write; set wins
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         done_ff <= 1'b0;
      end else if (state_buffer_load && func_out.done_preset) begin
         done_ff <= 1'b1;
      end else if (reg_wr && reg_addr == slt_pkg::ADDR_TXDATA) begin
         done_ff <= 1'b0;
      end
   end

   assign transmit_done = done_ff;

   // Data late: done still set at the next preset
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         late_ff <= 1'b0;
      end else if (state_buffer_load && func_out.done_preset && done_ff && sb_ff.active) begin
         late_ff <= 1'b1;
      end else if (reg_wr && reg_addr == slt_pkg::ADDR_OUTCTL
                   && reg_wdata[slt_pkg::OUT_SOM_BIT]) begin
         late_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software registers
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         mode_ff          <= 1'b0;
         table_disable_ff <= 1'b0;
      end else if (reg_wr && reg_addr == slt_pkg::ADDR_MAINT) begin
         mode_ff          <= reg_wdata[slt_pkg::MAINT_MODE_BIT];
         table_disable_ff <= reg_wdata[slt_pkg::MAINT_TDIS_BIT];
      end
   end

   // Silo control bits for the next character
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         som_ff <= 1'b0;
         eom_ff <= 1'b0;
      end else if (reg_wr && reg_addr == slt_pkg::ADDR_OUTCTL) begin
         som_ff <= reg_wdata[slt_pkg::OUT_SOM_BIT];
         eom_ff <= reg_wdata[slt_pkg::OUT_EOM_BIT];
      end
   end

   // Character data and sync pattern
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tx_data_ff <= 8'h00;
         sync_ff    <= slt_pkg::SYNC_RESET;
      end else if (reg_wr) begin
         if (reg_addr == slt_pkg::ADDR_TXDATA) begin
            tx_data_ff <= reg_wdata[7:0];
         end
         if (reg_addr == slt_pkg::ADDR_SYNC) begin
            sync_ff <= reg_wdata[7:0];
         end
      end
   end

   // Read data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdata_ff <= '0;
      end else if (reg_rd) begin
         rdata_ff <= '0;
         case (reg_addr)
            slt_pkg::ADDR_MAINT: begin
               rdata_ff[slt_pkg::MAINT_MODE_BIT] <= mode_ff;
               rdata_ff[slt_pkg::MAINT_TDIS_BIT] <= table_disable_ff;
            end
            slt_pkg::ADDR_OUTCTL: begin
               rdata_ff[slt_pkg::OUT_SOM_BIT] <= som_ff;
               rdata_ff[slt_pkg::OUT_EOM_BIT] <= eom_ff;
            end
            slt_pkg::ADDR_TXDATA: begin
               rdata_ff[7:0] <= tx_data_ff;
            end
            slt_pkg::ADDR_SYNC: begin
               rdata_ff[7:0] <= sync_ff;
            end
            slt_pkg::ADDR_STATUS: begin
               rdata_ff[slt_pkg::ST_DONE_BIT]   <= done_ff;
               rdata_ff[slt_pkg::ST_ACTIVE_BIT] <= sb_ff.active;
               rdata_ff[slt_pkg::ST_LATE_BIT]   <= late_ff;
               rdata_ff[slt_pkg::ST_SB_LSB +: 6] <= sb_ff;
            end
            default: begin
               rdata_ff <= '0;
            end
         endcase
      end else begin
         rdata_ff <= '0;
      end
   end

   assign reg_rdata = rdata_ff;

endmodule

/* verification/slt_tx_monitor.sv */
// Port-level checker for the transmit sequencer
`timescale 1ns/1ps
module slt_tx_monitor #(
   parameter int DATA_W = 16
) (
   input wire logic              clock,
   input wire logic              rstn,
   input wire logic [3:0]        reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic              modem_cts,
   input wire logic              modem_dsr,
   input wire logic              modem_tx_clock,
   input wire logic              no_check_bits_strap,
   input wire logic              tx_line,
   input wire logic              transmit_done
);
   logic       pin_q_ff;
   logic [3:0] since_fall_ff;
   logic       maint_dis_ff;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   ////////////////////////////////////////////////////////////
   // Cycles since the raw link clock fell
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pin_q_ff      <= 1'b1;
         since_fall_ff <= 4'hF;
      end else begin
         pin_q_ff      <= modem_tx_clock;
         since_fall_ff <= (pin_q_ff && !modem_tx_clock) ? 4'h0 :
                          since_fall_ff + {3'h0, since_fall_ff != 4'hF};
      end
   end

   // Shadow of the table disable bit
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         maint_dis_ff <= 1'b0;
      end else if (reg_wr && reg_addr == slt_pkg::ADDR_MAINT) begin
         maint_dis_ff <= reg_wdata[slt_pkg::MAINT_TDIS_BIT];
      end
   end

   ////////////////////////////////////////////////////////////
   sequence s_read_of(logic [3:0] a);
      $past(reg_rd) && $past(reg_addr) == a;
   endsequence
   sequence s_late_seen;
      s_read_of(slt_pkg::ADDR_STATUS) ##0 reg_rdata[slt_pkg::ST_LATE_BIT];
   endsequence
   sequence s_idle_seen;
      s_read_of(slt_pkg::ADDR_STATUS) ##0 reg_rdata[13:0] == 14'h0000;
   endsequence

   property p_reset_mark;
      $rose(rstn) |-> tx_line && !transmit_done && reg_rdata == '0;
   endproperty
   property p_line_on_tick;
      $changed(tx_line) |-> since_fall_ff >= 4'h1 && since_fall_ff <= 4'h5;
   endproperty
   property p_done_on_tick;
      $rose(transmit_done) |-> since_fall_ff >= 4'h1 && since_fall_ff <= 4'h5;
   endproperty
   property p_done_needs_send;
      $rose(transmit_done) |-> $past(modem_cts && modem_dsr, 3);
   endproperty
   property p_done_clear;
      $fell(transmit_done) |-> $past(reg_wr) && $past(reg_addr) == slt_pkg::ADDR_TXDATA;
   endproperty
   property p_disabled_no_done;
      maint_dis_ff |-> !$rose(transmit_done);
   endproperty
   property p_late_mark;
      s_late_seen |-> ##[1:10] tx_line [*8];
   endproperty
   property p_idle_mark;
      s_idle_seen |-> ##[0:9] tx_line [*8];
   endproperty

   a_reset_mark: assert property (p_reset_mark) else $error("line not idle after reset");
   a_line_on_tick: assert property (p_line_on_tick) else $error("line moved off bit time");
   a_done_on_tick: assert property (p_done_on_tick) else $error("done set off bit time");
   a_done_needs_send: assert property (p_done_needs_send) else $error("done without send");
   a_done_clear: assert property (p_done_clear) else $error("done cleared unprompted");
   a_disabled_no_done: assert property (p_disabled_no_done) else $error("disabled done");
   a_late_mark: assert property (p_late_mark) else $error("late line not at mark");
   a_idle_mark: assert property (p_idle_mark) else $error("idle line not at mark");
endmodule

bind slt_tx_sequencer slt_tx_monitor #(.DATA_W(DATA_W)) slt_tx_monitor_i (
   .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .modem_cts(modem_cts),
   .modem_dsr(modem_dsr), .modem_tx_clock(modem_tx_clock),
   .no_check_bits_strap(no_check_bits_strap), .tx_line(tx_line),
   .transmit_done(transmit_done));

/* verification/slt_modem_model.sv */
// Behavioural modem: transmit clock, send permission and line sampler
`timescale 1ns/1ps
module slt_modem_model (
   input  wire logic       grant,
   input  wire logic       clear_max,
   input  wire logic       tx_line,
   output logic            modem_tx_clock,
   output logic            modem_cts,
   output logic            modem_dsr,
   output logic      [7:0] ones_run,
   output logic      [7:0] max_ones
);
   logic [7:0] nxt_run;

   ////////////////////////////////////////////////////////////
   // Link clock runs free
   initial begin
      modem_tx_clock = 1'b1;
      #7;
      forever #160 modem_tx_clock = ~modem_tx_clock;
   end

   // Both permission lines follow grant
   assign modem_cts = grant;
   assign modem_dsr = grant;

   // Sample the line at each falling edge
   always @(negedge modem_tx_clock) begin
      nxt_run = tx_line ? ones_run + {7'h0, ones_run != 8'hFF} : 8'h00;
      ones_run <= clear_max ? 8'h00 : nxt_run;
      max_ones <= clear_max ? 8'h00 : ((nxt_run > max_ones) ? nxt_run : max_ones);
   end
endmodule

/* verification/slt_tx_sequencer_tb_top.sv */
// Self-checking bench for the transmit sequencer
`timescale 1ns/1ps
module slt_tx_sequencer_tb_top;
   logic        clock;
   logic        rstn;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic        modem_cts;
   logic        modem_dsr;
   logic        modem_tx_clock;
   logic        strap;
   logic        tx_line;
   logic        transmit_done;
   logic        grant;
   logic        clear_max;
   logic [7:0]  ones_run;
   logic [7:0]  max_ones;
   logic [15:0] d;
   int          mismatches;
   int          comparisons;

   slt_tx_sequencer #(.DATA_W(16)) slt_tx_sequencer_i (
      .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .modem_cts(modem_cts),
      .modem_dsr(modem_dsr), .modem_tx_clock(modem_tx_clock),
      .no_check_bits_strap(strap), .tx_line(tx_line), .transmit_done(transmit_done));

   slt_modem_model slt_modem_model_i (
      .grant(grant), .clear_max(clear_max), .tx_line(tx_line),
      .modem_tx_clock(modem_tx_clock), .modem_cts(modem_cts), .modem_dsr(modem_dsr),
      .ones_run(ones_run), .max_ones(max_ones));

   ////////////////////////////////////////////////////////////
   // System clock, 40 ns
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
         mismatches++;
      end
   endtask

   // One-cycle strobes
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic wait_done(input int bound);
      int n;
      for (n = 0; n < bound && transmit_done !== 1'b1; n++) begin
         @(posedge clock);
         #1;
      end
      chk("done wait", {15'h0, transmit_done}, 16'h0001);
      if (transmit_done !== 1'b1) conclude();
   endtask

   task automatic wait_status(input int b, input logic v);
      int n;
      rd(slt_pkg::ADDR_STATUS);
      for (n = 0; n < 400 && d[b] !== v; n++) rd(slt_pkg::ADDR_STATUS);
      chk("status wait", {15'h0, d[b]}, {15'h0, v});
      if (d[b] !== v) conclude();
   endtask

   ////////////////////////////////////////////////////////////
   task automatic t_regs();
      rd(slt_pkg::ADDR_SYNC);
      chk("sync reset", d, {8'h00, slt_pkg::SYNC_RESET});
      wr(slt_pkg::ADDR_SYNC, 16'hA55A);
      rd(slt_pkg::ADDR_SYNC);
      chk("sync rw", d, 16'h005A);
      wr(4'h2, 16'h00FF);
      rd(4'h2);
      chk("unmapped", d, 16'h0000);
      rd(slt_pkg::ADDR_STATUS);
      chk("idle status", d, 16'h0000);
   endtask

   // Start that must go nowhere
   task automatic t_blocked(input logic [15:0] maint, input logic ok);
      @(posedge clock);
      grant <= ok;
      wr(slt_pkg::ADDR_MAINT, maint);
      wr(slt_pkg::ADDR_OUTCTL, 16'h0001);
      repeat (320) @(posedge clock);
      #1;
      chk("blocked done", {15'h0, transmit_done}, 16'h0000);
      chk("blocked line", {15'h0, ones_run >= 8'h28}, 16'h0001);
      wr(slt_pkg::ADDR_OUTCTL, 16'h0000);
      repeat (16) @(posedge clock);
      wr(slt_pkg::ADDR_MAINT, 16'h0000);
      @(posedge clock);
      grant <= 1'b1;
   endtask

   task automatic t_message();
      wr(slt_pkg::ADDR_OUTCTL, 16'h0001);
      wait_done(200);
      @(posedge clock);
      clear_max <= 1'b1;
      rd(slt_pkg::ADDR_STATUS);
      chk("start status", d, 16'h2A03);
      // Start bit cleared mid-character
      wr(slt_pkg::ADDR_OUTCTL, 16'h0000);
      rd(slt_pkg::ADDR_STATUS);
      chk("buffer held", {10'h0, d[13:8]}, 16'h002A);
      @(posedge clock);
      clear_max <= 1'b0;
      repeat (2) begin
         wr(slt_pkg::ADDR_TXDATA, 16'h00FF);
         #1;
         chk("done cleared", {15'h0, transmit_done}, 16'h0000);
         wait_done(300);
      end
      chk("ones run", {15'h0, max_ones >= 8'h05 && max_ones <= 8'h06}, 16'h0001);
      wr(slt_pkg::ADDR_OUTCTL, 16'h0002);
      wr(slt_pkg::ADDR_TXDATA, 16'h003C);
      wait_status(slt_pkg::ST_ACTIVE_BIT, 1'b0);
      repeat (160) @(posedge clock);
      #1;
      chk("end idle", {15'h0, ones_run >= 8'h10}, 16'h0001);
      wr(slt_pkg::ADDR_OUTCTL, 16'h0000);
   endtask

   // Byte-count mode, done left unserviced
   task automatic t_late();
      @(posedge clock);
      strap <= 1'b1;
      wr(slt_pkg::ADDR_MAINT, 16'h0001);
      wr(slt_pkg::ADDR_OUTCTL, 16'h0001);
      wait_done(200);
      wr(slt_pkg::ADDR_OUTCTL, 16'h0000);
      wait_status(slt_pkg::ST_LATE_BIT, 1'b1);
      chk("late done", {15'h0, d[slt_pkg::ST_DONE_BIT]}, 16'h0001);
      repeat (160) @(posedge clock);
      #1;
      chk("late mark", {15'h0, ones_run >= 8'h10}, 16'h0001);
   endtask

   ////////////////////////////////////////////////////////////
   // Reset for 12 cycles, then scenarios
   initial begin
      rstn = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      strap = 1'b0;
      grant = 1'b1;
      clear_max = 1'b1;
      mismatches = 0;
      comparisons = 0;
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      clear_max <= 1'b0;
      repeat (4) @(posedge clock);
      t_regs();
      t_blocked(16'h0000, 1'b0);
      t_blocked(16'h0002, 1'b1);
      t_message();
      t_late();
      conclude();
   end
endmodule
